// ==== spr_pkg.sv ====
// Package with register map, field positions and types for the SCSI parity and residue status block.
package spr_pkg;

  localparam logic [3:0] ADDR_CTRL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
  localparam logic [3:0] ADDR_INT_EN_ZERO = 4'h2;
  localparam logic [3:0] ADDR_INT_ST_ZERO = 4'h3;
  localparam logic [3:0] ADDR_STATUS_ZERO = 4'h4;
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h5;
  localparam logic [3:0] ADDR_CHIP_TEST_FOUR = 4'h6;
  localparam logic [3:0] ADDR_DMA_STATUS = 4'h7;
  localparam logic [3:0] ADDR_DMA_INT_EN = 4'h8;
  localparam logic [3:0] ADDR_DMA_FIFO_COUNT = 4'h9;
  localparam logic [3:0] ADDR_DMA_BYTE_COUNTER = 4'ha;

  localparam int BIT_ATN_ON_PERR = 1;
  localparam int BIT_PARITY_CHECK = 3;
  localparam int BIT_EVEN_PARITY = 2;
  localparam int BIT_HALT_DISABLE = 5;
  localparam int BIT_PERR_INT_EN = 0;
  localparam int BIT_PERR_STATUS = 0;
  localparam int BIT_LIVE_PARITY = 0;
  localparam int BIT_OUT_LATCH_FULL = 5;
  localparam int BIT_OUT_HOLD_FULL = 6;
  localparam int BIT_IN_LATCH_FULL = 7;
  localparam int BIT_LATCHED_PARITY = 3;
  localparam int BIT_SYNC_COUNT_LO = 4;
  localparam int BIT_MASTER_PAR_EN = 3;
  localparam int BIT_MASTER_DPE = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_COUNT = 7'h00;

  localparam int FIFO_LANES = 4;
  localparam int FIFO_DEPTH = 20;

  // One received SCSI transfer, sampled from the active-low bus.
  typedef struct packed {
    logic strobe;
    logic [7:0] data;
    logic parity;
  } spr_rx_t;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } spr_req_t;

endpackage : spr_pkg

// ==== spr_fifo_level.sv ====
// Occupancy counter for the four-lane DMA FIFO, counting bytes up to lanes times depth.
`timescale 1ns/1ps
module spr_fifo_level
  import spr_pkg::*;
#(
  parameter int LANES = FIFO_LANES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  output logic [6:0] count,
  output logic full
);

  localparam logic [6:0] MAX_BYTES = 7'(LANES * DEPTH);

  wire do_push = push && (count != MAX_BYTES);
  wire do_pop = pop && (count != 7'h00);

  assign full = (count == MAX_BYTES);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count <= RESET_COUNT;
    end else if (ce) begin
      if (do_push && !do_pop) begin
        count <= count + 7'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 7'h01;
      end
    end
  end

endmodule : spr_fifo_level

// ==== spr_parity_status.sv ====
// SCSI parity generation and checking, PCI master parity status and data-path residue status.
`timescale 1ns/1ps
module spr_parity_status
  import spr_pkg::*;
#(
  parameter int LANES = FIFO_LANES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] scsi_data_n_in,
  input wire logic scsi_parity_line_n_in,
  input wire logic scsi_rx_strobe,
  output logic [7:0] scsi_data_n_out,
  output logic scsi_parity_line_n_out,
  output logic scsi_data_oe,
  input wire logic [7:0] tx_byte,
  input wire logic tx_load,
  input wire logic tx_hold_load,
  input wire logic tx_sent,
  input wire logic sync_mode,
  input wire logic rx_unload,
  input wire logic [3:0] sync_rx_count,
  input wire logic is_initiator,
  input wire logic is_target,
  input wire logic transfer_end,
  output logic attention_out_n,
  output logic halt_req,
  output logic scsi_perr_irq,
  input wire logic pci_master_data_phase,
  input wire logic pci_target_perr,
  output logic dma_irq,
  input wire logic dma_push,
  input wire logic dma_pop,
  input wire logic [6:0] dma_byte_counter,
  output logic dma_fifo_full
);

  // Bus pins come from outside the clock domain; two stages before use.
  logic [9:0] pin_s1;
  logic [9:0] pin_s2;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_s1 <= 10'h3ff;
      pin_s2 <= 10'h3ff;
    end else if (ce) begin
      pin_s1 <= {pci_target_perr, scsi_parity_line_n_in, scsi_data_n_in};
      pin_s2 <= pin_s1;
    end
  end

  wire [7:0] rx_data = ~pin_s2[7:0];
  wire rx_parity = ~pin_s2[8];
  wire target_perr_sync = pin_s2[9];

  logic [7:0] scsi_control_zero;
  logic [7:0] scsi_control_one;
  logic [7:0] scsi_int_enable_zero;
  logic [7:0] scsi_int_status_zero;
  logic [7:0] chip_test_four;
  logic [7:0] dma_status;
  logic [7:0] dma_int_enable;
  logic [7:0] scsi_in_latch;
  logic in_latch_parity;
  logic in_latch_full;
  logic [7:0] scsi_out_latch;
  logic out_latch_full;
  logic [7:0] scsi_out_holding;
  logic out_hold_full;
  logic attention_active;
  logic halt_pending;
  logic halt_active;
  logic [7:0] read_mux;
  logic [6:0] dma_fifo_count;

  wire atn_on_perr = scsi_control_zero[BIT_ATN_ON_PERR];
  wire parity_check_enable = scsi_control_zero[BIT_PARITY_CHECK];
  wire even_parity_select = scsi_control_one[BIT_EVEN_PARITY];
  wire halt_disable = scsi_control_one[BIT_HALT_DISABLE];
  wire parity_err_int_enable = scsi_int_enable_zero[BIT_PERR_INT_EN];
  wire master_par_en = chip_test_four[BIT_MASTER_PAR_EN];

  function automatic logic odd_parity_bit(input logic [7:0] d);
    odd_parity_bit = ~(^d);
  endfunction : odd_parity_bit

  // Reception: the synchronised byte and parity are latched on the strobe.
  wire rx_take = scsi_rx_strobe;
  wire rx_parity_bad = (rx_parity != odd_parity_bit(rx_data));
  wire perr_event = rx_take && parity_check_enable && rx_parity_bad;

  // Transmission: odd parity always computed, inverted for even sense.
  wire tx_parity = odd_parity_bit(scsi_out_latch) ^ even_parity_select;

  assign scsi_data_n_out = ~scsi_out_latch;
  assign scsi_parity_line_n_out = ~tx_parity;
  assign scsi_data_oe = out_latch_full;
  assign attention_out_n = ~attention_active;
  assign halt_req = halt_active;
  assign scsi_perr_irq = scsi_int_status_zero[BIT_PERR_STATUS] && parity_err_int_enable
    && parity_check_enable;
  assign dma_irq = dma_status[BIT_MASTER_DPE] && dma_int_enable[BIT_MASTER_DPE];

  wire mdpe_event = pci_master_data_phase && master_par_en && target_perr_sync;

  wire wr_c0 = reg_wr && (reg_addr == ADDR_CTRL_ZERO);
  wire wr_c1 = reg_wr && (reg_addr == ADDR_CTRL_ONE);
  wire wr_ie = reg_wr && (reg_addr == ADDR_INT_EN_ZERO);
  wire rd_is = reg_rd && (reg_addr == ADDR_INT_ST_ZERO);
  wire wr_ct4 = reg_wr && (reg_addr == ADDR_CHIP_TEST_FOUR);
  wire rd_ds = reg_rd && (reg_addr == ADDR_DMA_STATUS);
  wire wr_die = reg_wr && (reg_addr == ADDR_DMA_INT_EN);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scsi_control_zero <= RESET_BYTE;
      scsi_control_one <= RESET_BYTE;
      scsi_int_enable_zero <= RESET_BYTE;
      chip_test_four <= RESET_BYTE;
      dma_int_enable <= RESET_BYTE;
    end else if (ce) begin
      if (wr_c0) scsi_control_zero <= reg_wdata;
      if (wr_c1) scsi_control_one <= reg_wdata;
      if (wr_ie) scsi_int_enable_zero <= reg_wdata;
      if (wr_ct4) chip_test_four <= reg_wdata;
      if (wr_die) dma_int_enable <= reg_wdata;
    end
  end

  // Sticky status flags clear on read; a same-cycle event wins over the clear.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scsi_int_status_zero <= RESET_BYTE;
      dma_status <= RESET_BYTE;
    end else if (ce) begin
      if (perr_event) begin
        scsi_int_status_zero[BIT_PERR_STATUS] <= 1'b1;
      end else if (rd_is) begin
        scsi_int_status_zero[BIT_PERR_STATUS] <= 1'b0;
      end
      if (mdpe_event) begin
        dma_status[BIT_MASTER_DPE] <= 1'b1;
      end else if (rd_ds) begin
        dma_status[BIT_MASTER_DPE] <= 1'b0;
      end
    end
  end

  // Input latch holds the received byte and its parity until moved onward.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scsi_in_latch <= RESET_BYTE;
      in_latch_parity <= 1'b0;
      in_latch_full <= 1'b0;
    end else if (ce) begin
      if (rx_take) begin
        scsi_in_latch <= rx_data;
        in_latch_parity <= rx_parity;
        in_latch_full <= 1'b1;
      end else if (rx_unload) begin
        in_latch_full <= 1'b0;
      end
    end
  end

  // Output path: holding register feeds the out latch during synchronous send.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scsi_out_latch <= RESET_BYTE;
      out_latch_full <= 1'b0;
      scsi_out_holding <= RESET_BYTE;
      out_hold_full <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        scsi_out_latch <= tx_byte;
        out_latch_full <= 1'b1;
      end else if (tx_sent && sync_mode && out_hold_full) begin
        scsi_out_latch <= scsi_out_holding;
        out_latch_full <= 1'b1;
      end else if (tx_sent) begin
        out_latch_full <= 1'b0;
      end
      if (tx_hold_load && sync_mode) begin
        scsi_out_holding <= tx_byte;
        out_hold_full <= 1'b1;
      end else if (tx_sent && out_hold_full) begin
        out_hold_full <= 1'b0;
      end
    end
  end

  // Error reactions: attention for initiators, halt immediate or deferred to transfer end.
  wire halt_now = perr_event && (!halt_disable || !is_target);
  wire halt_defer = perr_event && halt_disable && is_target;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      attention_active <= 1'b0;
      halt_pending <= 1'b0;
      halt_active <= 1'b0;
    end else if (ce) begin
      if (perr_event && atn_on_perr && is_initiator) begin
        attention_active <= 1'b1;
      end else if (wr_c0 && !reg_wdata[BIT_ATN_ON_PERR]) begin
        attention_active <= 1'b0;
      end
      if (halt_defer) begin
        halt_pending <= 1'b1;
      end else if (transfer_end) begin
        halt_pending <= 1'b0;
      end
      if (halt_now || (halt_pending && transfer_end)) begin
        halt_active <= 1'b1;
      end else if (rd_is) begin
        halt_active <= 1'b0;
      end
    end
  end

  spr_fifo_level #(
    .LANES(LANES),
    .DEPTH(DEPTH)
  ) u_level (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .push(dma_push),
    .pop(dma_pop),
    .count(dma_fifo_count),
    .full(dma_fifo_full)
  );

  wire [7:0] status_zero = {in_latch_full, out_hold_full, out_latch_full, 4'h0,
    ~pin_s2[8]};
  wire [7:0] status_one = {sync_rx_count, in_latch_parity, 3'h0};

  always_comb begin
    if (reg_addr == ADDR_CTRL_ZERO) read_mux = scsi_control_zero;
    else if (reg_addr == ADDR_CTRL_ONE) read_mux = scsi_control_one;
    else if (reg_addr == ADDR_INT_EN_ZERO) read_mux = scsi_int_enable_zero;
    else if (reg_addr == ADDR_INT_ST_ZERO) read_mux = scsi_int_status_zero;
    else if (reg_addr == ADDR_STATUS_ZERO) read_mux = status_zero;
    else if (reg_addr == ADDR_STATUS_ONE) read_mux = status_one;
    else if (reg_addr == ADDR_CHIP_TEST_FOUR) read_mux = chip_test_four;
    else if (reg_addr == ADDR_DMA_STATUS) read_mux = dma_status;
    else if (reg_addr == ADDR_DMA_INT_EN) read_mux = dma_int_enable;
    else if (reg_addr == ADDR_DMA_FIFO_COUNT) read_mux = {1'b0, dma_fifo_count};
    else if (reg_addr == ADDR_DMA_BYTE_COUNTER) read_mux = {1'b0, dma_byte_counter};
    else read_mux = 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= RESET_BYTE;
    end else if (ce) begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

  property p_perr_flag;
    @(posedge mclk) disable iff (!nrst)
    ce && perr_event |=> scsi_int_status_zero[BIT_PERR_STATUS];
  endproperty
  a_perr_flag: assert property (p_perr_flag) else $error("parity flag not set");

  property p_no_check;
    @(posedge mclk) disable iff (!nrst)
    ce && !parity_check_enable && !scsi_int_status_zero[BIT_PERR_STATUS]
      |=> !scsi_int_status_zero[BIT_PERR_STATUS];
  endproperty
  a_no_check: assert property (p_no_check) else $error("error flagged with check off");

  property p_atn;
    @(posedge mclk) disable iff (!nrst)
    ce && perr_event && atn_on_perr && is_initiator |=> !attention_out_n;
  endproperty
  a_atn: assert property (p_atn) else $error("attention not asserted");

  property p_halt;
    @(posedge mclk) disable iff (!nrst)
    ce && perr_event && !halt_disable |=> halt_req;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on parity error");

  property p_defer;
    @(posedge mclk) disable iff (!nrst)
    ce && halt_defer && !transfer_end && !halt_req |=> !halt_req;
  endproperty
  a_defer: assert property (p_defer) else $error("target halted early");

  property p_irq_gate;
    @(posedge mclk) disable iff (!nrst)
    !parity_err_int_enable |-> !scsi_perr_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("parity irq while disabled");

  property p_mdpe;
    @(posedge mclk) disable iff (!nrst)
    ce && pci_master_data_phase && master_par_en && target_perr_sync
      |=> dma_status[BIT_MASTER_DPE];
  endproperty
  a_mdpe: assert property (p_mdpe) else $error("master parity status missed");

  property p_mdpe_irq;
    @(posedge mclk) disable iff (!nrst)
    !dma_int_enable[BIT_MASTER_DPE] |-> !dma_irq;
  endproperty
  a_mdpe_irq: assert property (p_mdpe_irq) else $error("master parity irq while disabled");

  property p_tx_parity;
    @(posedge mclk) disable iff (!nrst)
    scsi_data_oe |-> (^{~scsi_data_n_out, ~scsi_parity_line_n_out}) == !even_parity_select;
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("send parity sense wrong");

  property p_in_full;
    @(posedge mclk) disable iff (!nrst)
    ce && rx_take |=> status_zero[BIT_IN_LATCH_FULL];
  endproperty
  a_in_full: assert property (p_in_full) else $error("input latch not shown full");

endmodule : spr_parity_status

// ==== spr_scsi_peer.sv ====
// SCSI peer model that drives received bytes onto the active-low bus with good or bad parity.
`timescale 1ns/1ps
module spr_scsi_peer
  import spr_pkg::*;
(
  input wire logic drive,
  input wire logic [7:0] byte_val,
  input wire logic bad_par,
  output logic [7:0] data_n,
  output logic parity_n
);
  // Released lines float to the terminator pull-up, which reads as deasserted.
  assign data_n = drive ? ~byte_val : 8'hff;
  assign parity_n = drive ? ~(~^byte_val ^ bad_par) : 1'b1;
endmodule : spr_scsi_peer

// ==== scsi_parity_and_residue_status_test.sv ====
// Self-checking testbench for the SCSI parity and residue status block.
`timescale 1ns/1ps
module scsi_parity_and_residue_status_test;
  import spr_pkg::*;
  logic mclk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, scsi_rx_strobe = 0, tx_load = 0, tx_hold_load = 0;
  logic tx_sent = 0, sync_mode = 0, rx_unload = 0, is_initiator = 0, is_target = 0, transfer_end = 0;
  logic pci_master_data_phase = 0, pci_target_perr = 0, dma_push = 0, dma_pop = 0, peer_drive = 0, peer_bad = 0;
  logic [3:0] reg_addr = 0, sync_rx_count = 0;
  logic [7:0] reg_wdata = 0, tx_byte = 0, peer_byte = 0, rd_val, b;
  logic [6:0] dma_byte_counter = 0;
  logic [7:0] reg_rdata, scsi_data_n_out, peer_data_n;
  logic scsi_parity_line_n_out, scsi_data_oe, attention_out_n, halt_req, scsi_perr_irq, dma_irq, dma_fifo_full;
  logic peer_parity_n;
  int num_errors = 0, compares = 0;
  // Both ends are open-collector on the bus, so the wire is the AND of every driver.
  wire logic [7:0] bus_data_n = scsi_data_oe ? (scsi_data_n_out & peer_data_n) : peer_data_n;
  wire logic bus_parity_n = scsi_data_oe ? (scsi_parity_line_n_out & peer_parity_n) : peer_parity_n;

  always #20 mclk = ~mclk;

  spr_parity_status dut (.mclk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scsi_data_n_in(bus_data_n), .scsi_parity_line_n_in(bus_parity_n), .scsi_rx_strobe, .scsi_data_n_out,
    .scsi_parity_line_n_out, .scsi_data_oe, .tx_byte, .tx_load, .tx_hold_load, .tx_sent, .sync_mode, .rx_unload,
    .sync_rx_count, .is_initiator, .is_target, .transfer_end, .attention_out_n, .halt_req, .scsi_perr_irq,
    .pci_master_data_phase, .pci_target_perr, .dma_irq, .dma_push, .dma_pop, .dma_byte_counter, .dma_fifo_full);
  spr_scsi_peer peer (.drive(peer_drive), .byte_val(peer_byte), .bad_par(peer_bad), .data_n(peer_data_n),
    .parity_n(peer_parity_n));

  function automatic logic odd_bit(input logic [7:0] v);
    return ~^v;
  endfunction : odd_bit

  task automatic summarize;
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask : chb

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // The peer holds the byte past the two-flop synchroniser before the strobe takes it.
  task automatic rx(input logic [7:0] v, input logic bad);
    @(posedge mclk) {peer_byte, peer_bad, peer_drive} <= {v, bad, 1'b1};
    repeat (3) @(posedge mclk);
    scsi_rx_strobe <= 1;
    @(posedge mclk) scsi_rx_strobe <= 0;
    repeat (3) @(posedge mclk);
    peer_drive <= 0;
    #1;
  endtask : rx

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(23));
    repeat (5) @(posedge mclk);
    nrst <= 1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      chk("reset value", 8'h00, rd_val);
    end
    chb("attention idle", 1'b1, attention_out_n);
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h00 : (i == 7) ? 8'hff : 8'($urandom);
      wr(ADDR_CTRL_ZERO, {4'h0, i[1], 3'h0});
      wr(ADDR_CTRL_ONE, {5'h0, i[0], 2'h0});
      @(posedge mclk) {tx_byte, tx_load} <= {b, 1'b1};
      @(posedge mclk) tx_load <= 0;
      #1 chk("tx data", ~b, scsi_data_n_out);
      chb("tx parity", ~(odd_bit(b) ^ i[0]), scsi_parity_line_n_out);
      chb("tx enable", 1'b1, scsi_data_oe);
      rd(ADDR_STATUS_ZERO);
      chb("out latch full", 1'b1, rd_val[BIT_OUT_LATCH_FULL]);
      @(posedge mclk) tx_sent <= 1;
      @(posedge mclk) tx_sent <= 0;
      rd(ADDR_STATUS_ZERO);
      chb("out latch empty", 1'b0, rd_val[BIT_OUT_LATCH_FULL]);
    end
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      wr(ADDR_INT_EN_ZERO, {7'h0, i[2]});
      wr(ADDR_CTRL_ZERO, {4'h0, i[1], 3'h0});
      wr(ADDR_CTRL_ONE, 8'h00);
      rx(b, i[0]);
      chb("parity irq", i[0] & i[1] & i[2], scsi_perr_irq);
      chb("halt", i[0] & i[1], halt_req);
      rd(ADDR_STATUS_ZERO);
      chb("in latch full", 1'b1, rd_val[BIT_IN_LATCH_FULL]);
      rd(ADDR_STATUS_ONE);
      if (!i[0]) chb("latched parity", odd_bit(b), rd_val[BIT_LATCHED_PARITY]);
      rd(ADDR_INT_ST_ZERO);
      chb("parity error flag", i[0] & i[1], rd_val[BIT_PERR_STATUS]);
      @(posedge mclk) rx_unload <= 1;
      @(posedge mclk) rx_unload <= 0;
      rd(ADDR_STATUS_ZERO);
      chb("in latch moved", 1'b0, rd_val[BIT_IN_LATCH_FULL]);
    end
    wr(ADDR_CTRL_ZERO, 8'h0a);
    @(posedge mclk) is_initiator <= 1;
    rx(8'($urandom), 1'b1);
    chb("attention", 1'b0, attention_out_n);
    rd(ADDR_INT_ST_ZERO);
    wr(ADDR_CTRL_ZERO, 8'h08);
    @(posedge mclk) {is_initiator, is_target} <= 2'b01;
    wr(ADDR_CTRL_ONE, 8'h20);
    wr(ADDR_INT_EN_ZERO, 8'h01);
    wr(ADDR_CTRL_ZERO, 8'h0a);
    rx(8'($urandom), 1'b1);
    chb("target attention", 1'b1, attention_out_n);
    chb("deferred halt", 1'b0, halt_req);
    chb("target irq", 1'b1, scsi_perr_irq);
    @(posedge mclk) transfer_end <= 1;
    @(posedge mclk) transfer_end <= 0;
    @(posedge mclk) #1 chb("halt at end", 1'b1, halt_req);
    rd(ADDR_INT_ST_ZERO);
    @(posedge mclk) {peer_byte, peer_bad, peer_drive} <= {8'h00, 1'b0, 1'b1};
    repeat (3) @(posedge mclk);
    rd(ADDR_STATUS_ZERO);
    chb("live parity", odd_bit(8'h00), rd_val[BIT_LIVE_PARITY]);
    @(posedge mclk) peer_drive <= 0;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CHIP_TEST_FOUR, {4'h0, i[0], 3'h0});
      wr(ADDR_DMA_INT_EN, {1'b0, i[1], 6'h0});
      @(posedge mclk) {pci_master_data_phase, pci_target_perr} <= 2'b11;
      repeat (4) @(posedge mclk);
      {pci_master_data_phase, pci_target_perr} <= 2'b00;
      repeat (2) @(posedge mclk);
      #1 chb("dma irq", i[0] & i[1], dma_irq);
      rd(ADDR_DMA_STATUS);
      chb("master parity error", i[0], rd_val[BIT_MASTER_DPE]);
    end
    @(posedge mclk) {sync_mode, sync_rx_count, tx_byte, tx_hold_load} <= {1'b1, 4'($urandom), 8'($urandom), 1'b1};
    @(posedge mclk) tx_hold_load <= 0;
    rd(ADDR_STATUS_ZERO);
    chb("holding full", 1'b1, rd_val[BIT_OUT_HOLD_FULL]);
    rd(ADDR_STATUS_ONE);
    chk("sync count", {4'h0, sync_rx_count}, {4'h0, rd_val[7:4]});
    repeat (80) @(posedge mclk) dma_push <= 1;
    @(posedge mclk) {dma_push, dma_byte_counter} <= {1'b0, 7'($urandom)};
    #1 chb("fifo full", 1'b1, dma_fifo_full);
    rd(ADDR_DMA_FIFO_COUNT);
    chk("fifo count", 8'h50, rd_val);
    rd(ADDR_DMA_BYTE_COUNTER);
    chk("residue", (8'h50 - {1'b0, dma_byte_counter}) & 8'h7f, (8'h50 - rd_val) & 8'h7f);
    @(posedge mclk) dma_pop <= 1;
    @(posedge mclk) dma_pop <= 0;
    #1 chb("fifo not full", 1'b0, dma_fifo_full);
    rd(ADDR_DMA_FIFO_COUNT);
    chk("fifo count", 8'h4f, rd_val);
    @(posedge mclk) {ce, dma_pop} <= 2'b01;
    @(posedge mclk) {ce, dma_pop} <= 2'b10;
    rd(ADDR_DMA_FIFO_COUNT);
    chk("frozen count", 8'h4f, rd_val);
    @(posedge mclk) nrst <= 0;
    @(posedge mclk) nrst <= 1;
    rd(ADDR_DMA_FIFO_COUNT);
    chk("count after reset", 8'h00, rd_val);
    rd(ADDR_STATUS_ZERO);
    chb("holding after reset", 1'b0, rd_val[BIT_OUT_HOLD_FULL]);
    summarize();
  end
endmodule : scsi_parity_and_residue_status_test
